// [hdl/pzs_map.svh]
/*
 Constants of the pattern generator: degrees, feedback taps, seed,
 counter widths and buffer shape.
 Assumes inclusion by bare name from the generator and the port checker.
*/
`ifndef PZS_MAP_SVH
`define PZS_MAP_SVH

// degrees of the selectable generating polynomials
`define PZS_DEG7 5'h07
`define PZS_DEG9 5'h09
`define PZS_DEG10 5'h0A
`define PZS_DEG11 5'h0B
`define PZS_DEG13 5'h0D
`define PZS_DEG15 5'h0F
`define PZS_DEG20 5'h14
`define PZS_DEG23 5'h17
`define PZS_DEG31 5'h1F

// inner feedback stage of each polynomial (the outer one is the degree)
`define PZS_TAP7 5'h06
`define PZS_TAP9 5'h05
`define PZS_TAP10 5'h07
`define PZS_TAP11 5'h09
`define PZS_TAP13_A 5'h01
`define PZS_TAP13_B 5'h02
`define PZS_TAP13_C 5'h0C
`define PZS_TAP15 5'h0E
`define PZS_TAP20 5'h03
`define PZS_TAP23 5'h12
`define PZS_TAP31 5'h1C

// shift register
`define PZS_SR_W 31
`define PZS_SEED 31'h7FFFFFFF

// zero run counters
`define PZS_LEN_W 24
`define PZS_RAW_W 5
`define PZS_RAW_MAX 5'h1F

// output buffer: {period start mark, pin level}
`define PZS_FIFO_W 2
`define PZS_FIFO_DEPTH 8

`endif

// [hdl/pzs_pkg.sv]
/*
 Types of the pattern generator: polynomial selection and the
 zero substitution sequencer states.
 Assumes nothing of its surroundings.
*/
package pzs_pkg;

   typedef enum logic [3:0] {
      PZS_P7 = 4'h0,
      PZS_P9 = 4'h1,
      PZS_P10 = 4'h2,
      PZS_P11 = 4'h3,
      PZS_P13 = 4'h4,
      PZS_P15 = 4'h5,
      PZS_P20 = 4'h6,
      PZS_P23 = 4'h7,
      PZS_P31 = 4'h8
   } pzs_poly_t;

   typedef enum logic {
      PZS_ZS_IDLE = 1'h0,
      PZS_ZS_FORCE = 1'h1
   } pzs_zs_state_t;

endpackage

// [hdl/pzs_stream_if.sv]
/*
 Valid/ready word stream between the generator and its output buffer.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface pzs_stream_if #(
   parameter int W = 1
);
   logic [W-1:0] data;
   logic valid;
   logic ready;

   modport src (
      output data,
      output valid,
      input ready
   );

   modport snk (
      input data,
      input valid,
      output ready
   );
endinterface

`default_nettype wire

// [hdl/pzs_fifo.sv]
/*
 Word buffer with valid/ready on both sides and honest full/empty.
 Assumes a single clock and an active low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pzs_fifo #(
   parameter int W = 2,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // streams
   pzs_stream_if.snk in_s,
   pzs_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt;
   logic [AW-1:0] rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push;
   logic pop;

   assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_s.valid = (cnt_r != '0);
   assign out_s.data = mem[rd_r];
   assign push = in_s.valid & in_s.ready;
   assign pop = out_s.valid & out_s.ready;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      cnt_nxt = cnt_r;
      if (push) begin
         wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
         rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // storage needs no reset; nothing is read before it is written
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_r] <= in_s.data;
      end
   end
endmodule

`default_nettype wire

// [hdl/pzs_gen.sv]
/*
 Serial pseudo-random pattern source with optional zero substitution
 and selectable output polarity, feeding an 8 word output buffer.
 Assumes one 50 MHz clock, asynchronous active low reset, and a sink
 that takes bits with pat_valid/pat_ready.
 Setup inputs are levels sampled on every clock. A change of
 pattern_sel reseeds at the next edge and pushes nothing in that
 cycle. Polarity and substitution changes reach only bits generated
 afterwards, so up to eight buffered bits still carry the old setting.
 Codes of pattern_sel beyond the last polynomial run the longest one.
 A full buffer stalls the generator; no bit is ever dropped.

 // How it works
 // - LFSR of degree n, period 2^n-1
 // - one run of n ones per period
 // - positive polarity: one low, zero high
 // - degree 7 taps at 6 and 7
 // - degree 9 taps at 5 and 9
 // - degree 10 taps at 7 and 10
 // - degree 11 taps at 9 and 11
 // - degree 13 taps at 1, 2, 12, 13
 // - degree 15 taps at 14 and 15
 // - degree 20 taps at 3 and 20
 // - degree 23 taps at 18 and 23
 // - degree 31 taps at 28 and 31
 // - force zeros after longest natural zero run
 // - zero right after forced run becomes one
 // - degrees 7,9,10,11,13,15,20,23,31 selectable
 // - substitution lengths 2^n and 2^n-1 offered
*/
`timescale 1ns/1ps
`default_nettype none
`include "pzs_map.svh"

module pzs_gen (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pattern setup
   input wire pzs_pkg::pzs_poly_t pattern_sel,
   input wire logic zero_subst_en,
   input wire logic zs_full_pow,
   input wire logic [`PZS_LEN_W-1:0] zs_run_len,
   input wire logic inverted_polarity,
   // serial pattern out
   output logic pat_level,
   output logic pat_sync,
   output logic pat_valid,
   input wire logic pat_ready,
   // status
   output logic zs_active
);

   // degree of each selectable polynomial
   function automatic logic [4:0] deg_of(input pzs_pkg::pzs_poly_t p);
      unique case (p)
         pzs_pkg::PZS_P7: return `PZS_DEG7;
         pzs_pkg::PZS_P9: return `PZS_DEG9;
         pzs_pkg::PZS_P10: return `PZS_DEG10;
         pzs_pkg::PZS_P11: return `PZS_DEG11;
         pzs_pkg::PZS_P13: return `PZS_DEG13;
         pzs_pkg::PZS_P15: return `PZS_DEG15;
         pzs_pkg::PZS_P20: return `PZS_DEG20;
         pzs_pkg::PZS_P23: return `PZS_DEG23;
         pzs_pkg::PZS_P31: return `PZS_DEG31;
         // unused codes fall back to the longest sequence
         default: return `PZS_DEG31;
      endcase
   endfunction

   // inner tap of the two-tap polynomials
   function automatic logic [4:0] tap_of(input pzs_pkg::pzs_poly_t p);
      unique case (p)
         pzs_pkg::PZS_P7: return `PZS_TAP7;
         pzs_pkg::PZS_P9: return `PZS_TAP9;
         pzs_pkg::PZS_P10: return `PZS_TAP10;
         pzs_pkg::PZS_P11: return `PZS_TAP11;
         pzs_pkg::PZS_P15: return `PZS_TAP15;
         pzs_pkg::PZS_P20: return `PZS_TAP20;
         pzs_pkg::PZS_P23: return `PZS_TAP23;
         pzs_pkg::PZS_P31: return `PZS_TAP31;
         // degree 13 has four taps and is handled in fb_of
         default: return `PZS_TAP31;
      endcase
   endfunction

   // feedback bit: stage n xor inner taps
   function automatic logic fb_of(input pzs_pkg::pzs_poly_t p,
                                  input logic [`PZS_SR_W-1:0] s);
      logic [4:0] d;
      d = deg_of(p);
      if (p == pzs_pkg::PZS_P13) begin
         return s[d - 5'h01] ^ s[`PZS_TAP13_C - 5'h01] ^
                s[`PZS_TAP13_B - 5'h01] ^ s[`PZS_TAP13_A - 5'h01];
      end
      return s[d - 5'h01] ^ s[tap_of(p) - 5'h01];
   endfunction

   // bits of the register that belong to a degree
   function automatic logic [`PZS_SR_W-1:0] mask_of(input logic [4:0] d);
      logic [31:0] m;
      m = (32'h00000001 << d) - 32'h00000001;
      return m[`PZS_SR_W-1:0];
   endfunction

   // generator to buffer and buffer to pins
   pzs_stream_if #(.W(`PZS_FIFO_W)) gen_s ();
   pzs_stream_if #(.W(`PZS_FIFO_W)) pin_s ();

   // the buffer lets the sink stall without losing the period mark
   pzs_fifo #(
      .W(`PZS_FIFO_W),
      .DEPTH(`PZS_FIFO_DEPTH)
   ) pzs_fifo_inst (
      .clk(clk),
      .rst_n(rst_n),
      .in_s(gen_s),
      .out_s(pin_s)
   );

   // generator state
   // shift register and the polynomial it runs
   logic [`PZS_SR_W-1:0] lfsr_r;
   logic [`PZS_SR_W-1:0] lfsr_nxt;
   pzs_pkg::pzs_poly_t sel_r;
   pzs_pkg::pzs_poly_t sel_nxt;
   // substitution sequencer and its forced run length
   pzs_pkg::pzs_zs_state_t zs_r;
   pzs_pkg::pzs_zs_state_t zs_nxt;
   logic [`PZS_LEN_W-1:0] run_r;
   logic [`PZS_LEN_W-1:0] run_nxt;
   // raw zeros seen in a row, saturating
   logic [`PZS_RAW_W-1:0] raw_zero_r;
   logic [`PZS_RAW_W-1:0] raw_zero_nxt;

   logic [4:0] deg;
   logic [`PZS_LEN_W-1:0] deg_w;
   logic [`PZS_LEN_W-1:0] nat_run;
   logic raw_bit;
   logic gen_bit;
   logic step;
   logic adv;
   logic reseed;
   logic at_seed;
   logic at_natural_end;
   logic period_mark;
   logic pin_bit;

   assign deg = deg_of(sel_r);
   assign deg_w = `PZS_LEN_W'(deg);
   // longest natural zero run of a maximal sequence is n-1
   assign nat_run = deg_w - `PZS_LEN_W'(1);
   // output stage is stage n; stage k sits in bit k-1
   assign raw_bit = lfsr_r[deg - 5'h01];
   // a bit moves only when the buffer takes it
   assign adv = gen_s.valid & gen_s.ready;
   // compared with the registered copy, so a change costs one bit slot
   assign reseed = (pattern_sel != sel_r);
   // period start: register back at the seed value
   assign at_seed = ((lfsr_r & mask_of(deg)) == (`PZS_SEED & mask_of(deg)));
   // longest natural zero run (n-1) just went out
   assign at_natural_end = (raw_zero_r == `PZS_RAW_W'(deg - 5'h01));

   // the reseed cycle pushes nothing: its register still holds the old
   // polynomial's state and would put a stale bit ahead of the new seed
   assign gen_s.valid = ~reseed;
   // no mark on a forced bit, the period start stays unambiguous
   assign period_mark = at_seed & (zs_r == pzs_pkg::PZS_ZS_IDLE);
   // level 1 on the pin for a zero unless inverted
   // inversion only flips the pin, the sequence runs on
   assign pin_bit = gen_bit ^ ~inverted_polarity;
   assign gen_s.data = {period_mark, pin_bit};

   // sequencer: which bit goes out, and whether the register steps
   always_comb begin
      zs_nxt = zs_r;
      run_nxt = run_r;
      gen_bit = raw_bit;
      step = 1'b1;

      unique case (zs_r)
         pzs_pkg::PZS_ZS_IDLE: begin
            if (zero_subst_en && at_natural_end) begin
               if (zs_full_pow) begin
                  // extra zero stretches the period to 2^n
                  gen_bit = 1'b0;
                  step = 1'b0;
                  run_nxt = deg_w;
                  zs_nxt = pzs_pkg::PZS_ZS_FORCE;
               end else if (nat_run < zs_run_len) begin
                  // a wanted run no longer than n-1 leaves the pattern alone
                  gen_bit = 1'b0;
                  run_nxt = deg_w;
                  zs_nxt = pzs_pkg::PZS_ZS_FORCE;
               end
            end
         end
         pzs_pkg::PZS_ZS_FORCE: begin
            // switching substitution off drops the forcing at once
            if (!zero_subst_en) begin
               zs_nxt = pzs_pkg::PZS_ZS_IDLE;
            end else if (run_r < zs_run_len) begin
               // forced zeros still step the register, so the period is kept
               gen_bit = 1'b0;
               run_nxt = run_r + `PZS_LEN_W'(1);
            end else begin
               // zero that would lengthen the run is turned to one
               if (!raw_bit) begin
                  gen_bit = 1'b1;
               end
               zs_nxt = pzs_pkg::PZS_ZS_IDLE;
            end
         end
      endcase

      // nothing moves while the buffer is full or a reseed is pending
      if (!adv) begin
         zs_nxt = zs_r;
         run_nxt = run_r;
         step = 1'b0;
      end

      // a new polynomial also restarts the substitution
      if (reseed) begin
         run_nxt = '0;
         zs_nxt = pzs_pkg::PZS_ZS_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zs_r <= pzs_pkg::PZS_ZS_IDLE;
         run_r <= '0;
      end else begin
         zs_r <= zs_nxt;
         run_r <= run_nxt;
      end
   end

   // shift register: one stage per accepted bit, except the extra zero that stretches the period to 2^n
   always_comb begin
      lfsr_nxt = lfsr_r;
      sel_nxt = pattern_sel;
      if (step) begin
         lfsr_nxt = {lfsr_r[`PZS_SR_W-2:0], fb_of(sel_r, lfsr_r)};
      end
      // all-zero lock-up cannot hold; reload the seed
      if ((lfsr_nxt & mask_of(deg)) == '0) begin
         lfsr_nxt = `PZS_SEED;
      end
      // a new polynomial restarts from the seed
      if (reseed) begin
         lfsr_nxt = `PZS_SEED;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_r <= `PZS_SEED;
         sel_r <= pzs_pkg::PZS_P31;
      end else begin
         lfsr_r <= lfsr_nxt;
         sel_r <= sel_nxt;
      end
   end

   // raw zero run counter; it finds the end of the longest natural run
   always_comb begin
      raw_zero_nxt = raw_zero_r;
      if (step) begin
         if (raw_bit) begin
            raw_zero_nxt = '0;
         end else if (raw_zero_r != `PZS_RAW_MAX) begin
            raw_zero_nxt = raw_zero_r + `PZS_RAW_W'(1);
         end
      end
      if (reseed) begin
         raw_zero_nxt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_zero_r <= '0;
      end else begin
         raw_zero_r <= raw_zero_nxt;
      end
   end

   // maximal polynomials give the single run of n ones
   // pin side: level and mark straight from buffer storage
   assign pin_s.ready = pat_ready;
   assign pat_valid = pin_s.valid;
   // level reads 0 while empty so the pin never shows stale storage
   assign pat_level = pin_s.valid ? pin_s.data[0] : 1'b0;
   assign pat_sync = pin_s.valid ? pin_s.data[1] : 1'b0;
   // status straight from the sequencer register
   assign zs_active = (zs_r == pzs_pkg::PZS_ZS_FORCE);

endmodule

`default_nettype wire

// [verif/pzs_gen_asserts.sv]
/*
 Port checker for the pattern source.
 Assumes binding to pzs_gen, one clock, active low async reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pzs_map.svh"

module pzs_gen_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // setup
   input wire pzs_pkg::pzs_poly_t pattern_sel,
   input wire logic zero_subst_en,
   input wire logic zs_full_pow,
   input wire logic [`PZS_LEN_W-1:0] zs_run_len,
   input wire logic inverted_polarity,
   // stream
   input wire logic pat_level,
   input wire logic pat_sync,
   input wire logic pat_valid,
   input wire logic pat_ready,
   input wire logic zs_active
);
   logic take;
   logic gen;
   logic [15:0] cnt_r, cnt_nxt;
   logic [23:0] zr_r, zr_nxt;
   logic [5:0] or_r, or_nxt;
   assign take = pat_valid && pat_ready;
   // generated bit, undoing the pin polarity
   assign gen = pat_level ^ ~inverted_polarity;

   always_comb begin
      cnt_nxt = cnt_r;
      zr_nxt = zr_r;
      or_nxt = or_r;
      if (take) begin
         cnt_nxt = pat_sync ? 16'h0001 : cnt_r + 16'h0001;
         zr_nxt = gen ? 24'h000000 : zr_r + 24'h000001;
         or_nxt = gen ? or_r + 6'h01 : 6'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 16'h0000;
         zr_r <= 24'h000000;
         or_r <= 6'h00;
      end else begin
         cnt_r <= cnt_nxt;
         zr_r <= zr_nxt;
         or_r <= or_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence first_push_s;
      $rose(rst_n) ##[0:3] $rose(pat_valid);
   endsequence

   first_valid_a: assert property ($rose(rst_n) |-> ##[1:3] pat_valid)
      else $error("no bit after reset");
   first_bit_a: assert property (first_push_s |-> pat_sync && gen)
      else $error("first bit wrong");
   stall_hold_a: assert property (pat_valid && !pat_ready |=>
      pat_valid && $stable(pat_level) && $stable(pat_sync))
      else $error("bit changed while stalled");
   sync_level_a: assert property (take && pat_sync |-> gen)
      else $error("period start bit not one");
   ones_run_a: assert property (pattern_sel == pzs_pkg::PZS_P7 |-> or_r <= 6'h07)
      else $error("ones run too long");
   sync_period_a: assert property (take && pat_sync && cnt_r != 16'h0000 &&
      pattern_sel == pzs_pkg::PZS_P7 && !zero_subst_en |-> cnt_r == 16'h007F)
      else $error("period length wrong");
   zs_len_a: assert property (zero_subst_en |-> zr_r <= zs_run_len)
      else $error("zero run too long");
   zs_gate_a: assert property (zs_active |-> zero_subst_en || $past(zero_subst_en))
      else $error("forcing while disabled");
endmodule

bind pzs_gen pzs_gen_asserts pzs_gen_asserts_inst (.clk, .rst_n, .pattern_sel,
   .zero_subst_en, .zs_full_pow, .zs_run_len, .inverted_polarity, .pat_level,
   .pat_sync, .pat_valid, .pat_ready, .zs_active);

`default_nettype wire

// [verif/pzs_sink.sv]
/*
 Sink model taking pattern bits, optionally stalling one cycle in four.
 Assumes the same clock as the source; hands each taken bit on.
*/
`timescale 1ns/1ps
`default_nettype none

module pzs_sink (
   // clock and control
   input wire logic clk,
   input wire logic rst_n,
   input wire logic stall_en,
   // stream
   input wire logic pat_valid,
   input wire logic pat_level,
   input wire logic pat_sync,
   output logic pat_ready,
   // taken bit
   output logic got,
   output logic got_level,
   output logic got_sync
);
   logic [1:0] ph = 2'h0;

   // ready moves only at the falling edge, away from sampling
   always @(negedge clk) begin
      ph <= ph + 2'h1;
      pat_ready <= rst_n && !(stall_en && ph == 2'h3);
   end

   always @(posedge clk) begin
      got <= pat_valid && pat_ready;
      got_level <= pat_level;
      got_sync <= pat_sync;
   end
endmodule

`default_nettype wire

// [verif/tb_top.sv]
/*
 Testbench for the pattern source: taps, periods, runs, zero substitution.
 Assumes the sink model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   pzs_pkg::pzs_poly_t pattern_sel = pzs_pkg::PZS_P7;
   logic zero_subst_en = 1'b0;
   logic zs_full_pow = 1'b0;
   logic [23:0] zs_run_len = 24'h000000;
   logic inverted_polarity = 1'b0;
   logic stall_en = 1'b0;
   logic pat_level, pat_sync, pat_valid, pat_ready, zs_active, got, got_level, got_sync;
   int failures = 0;
   int comparisons = 0;
   int deg[9] = '{7, 9, 10, 11, 13, 15, 20, 23, 31};
   int tap[9] = '{6, 5, 7, 9, 12, 14, 3, 18, 28};
   logic [1:0] q[$];

   always #10 clk = ~clk;

   pzs_gen pzs_gen_inst (.clk, .rst_n, .pattern_sel, .zero_subst_en, .zs_full_pow,
      .zs_run_len, .inverted_polarity, .pat_level, .pat_sync, .pat_valid, .pat_ready,
      .zs_active);
   pzs_sink pzs_sink_inst (.clk, .rst_n, .stall_en, .pat_valid, .pat_level, .pat_sync,
      .pat_ready, .got, .got_level, .got_sync);

   always @(negedge clk) if (got) q.push_back({got_sync, got_level});

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // config only changes inside reset, so no buffered bit carries an old setting
   task automatic setup(input int sel, input logic zs, input logic fp, input int len,
                        input logic inv, input logic st);
      @(negedge clk);
      rst_n = 1'b0;
      pattern_sel = pzs_pkg::pzs_poly_t'(sel);
      zero_subst_en = zs;
      zs_full_pow = fp;
      zs_run_len = 24'(len);
      inverted_polarity = inv;
      stall_en = st;
      repeat (3) @(negedge clk);
      q.delete();
      rst_n = 1'b1;
   endtask

   task automatic get_bit(output logic g, output logic s);
      int i;
      for (i = 0; i < 100 && q.size() == 0; i++) begin
         @(negedge clk);
         #1;
      end
      if (q.size() == 0) begin
         failures++;
         print_verdict();
      end
      {s, g} = q.pop_front();
      g = g ^ ~inverted_polarity;
   endtask

   function automatic logic [30:0] step(input logic [30:0] s, input int n, input int t);
      logic nb;
      nb = s[n-1] ^ s[t-1];
      if (n == 13) nb = nb ^ s[0] ^ s[1];
      return {s[29:0], nb};
   endfunction

   task automatic test_taps;
      logic [30:0] s;
      logic g, y;
      int k, i;
      for (k = 0; k < 9; k++) begin
         setup(k, 1'b0, 1'b0, 0, k[0], k[1]);
         s = '1;
         for (i = 0; i < 200; i++) begin
            get_bit(g, y);
            if (i == 0) check("first sync", y, 1);
            check("prbs bit", g, s[deg[k]-1]);
            s = step(s, deg[k], tap[k]);
         end
      end
      $display("test taps done");
   endtask

   // one period from a sync bit: length, longest runs, count of full ones runs
   task automatic measure(input int n, output int per, output int mo, output int mz,
                          output int nr);
      logic g, y;
      int o, z;
      per = 0;
      o = 0;
      z = 0;
      mo = 0;
      mz = 0;
      nr = 0;
      get_bit(g, y);
      while (per < 2000) begin
         per++;
         o = g ? o + 1 : 0;
         z = g ? 0 : z + 1;
         if (o > mo) mo = o;
         if (z > mz) mz = z;
         if (o == n) nr++;
         get_bit(g, y);
         if (y) break;
      end
   endtask

   task automatic test_period;
      int p, mo, mz, nr, k;
      for (k = 0; k < 3; k++) begin
         setup(k, 1'b0, 1'b0, 0, k[0], 1'b1);
         measure(deg[k], p, mo, mz, nr);
         check("period", p, (1 << deg[k]) - 1);
         check("ones run", mo, deg[k]);
         check("ones runs", nr, 1);
         check("zero run", mz, deg[k] - 1);
      end
      $display("test period done");
   endtask

   task automatic test_zs;
      int sel[3] = '{0, 0, 1};
      int len[3] = '{10, 7, 9};
      int p, mo, mz, nr, k;
      for (k = 0; k < 3; k++) begin
         setup(sel[k], 1'b1, k != 0, len[k], k[1], k[0]);
         measure(deg[sel[k]], p, mo, mz, nr);
         check("zs period", p, (1 << deg[sel[k]]) - (k == 0));
         check("zs zero run", mz, len[k]);
      end
      $display("test zero substitution done");
   endtask

   initial begin
      repeat (3) @(negedge clk);
      test_taps();
      test_period();
      test_zs();
      print_verdict();
   end
endmodule

`default_nettype wire
